// *** rtl/slpg_pkg.sv ***
package slpg_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // Pattern times in ms
  localparam int unsigned SLOW_BLINK_MS = 600;
  localparam int unsigned DPULSE_MS = 75;
  localparam int unsigned DPULSE_GAP_MS = 3000;
  localparam int unsigned XFER_WAIT_MS = 1000;
  localparam int unsigned XFER_FLASH_MS = 500;
  localparam int unsigned COL_PHASE_MS = 50;
  // Double-pulse phase boundaries in ms
  localparam int unsigned DP_OFF1_MS = DPULSE_MS;
  localparam int unsigned DP_ON2_MS = 2 * DPULSE_MS;
  localparam int unsigned DP_OFF2_MS = 3 * DPULSE_MS;
  localparam int unsigned DP_END_MS = 3 * DPULSE_MS + DPULSE_GAP_MS;
  localparam int unsigned MS_W = 12;

  // Network-status conditions from the control logic
  typedef struct packed {
    logic carrier_off;
    logic sleep;
    logic alarm;
    logic sim_absent;
    logic pin_missing;
    logic net_search;
    logic user_auth;
    logic net_login;
    logic ctx_active;
    logic xfer_active;
    logic pkt_exchanged;
    logic voice_connected;
    logic data_connected;
    logic data_setup;
  } slpg_net_t;

  typedef enum logic [2:0] {
    SLPG_OFF, SLPG_SLOW, SLPG_DPULSE, SLPG_XFER, SLPG_STEADY
  } slpg_mode_t;
endpackage

// *** rtl/slpg_top.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Network lamp dark when carrier off, sleeping or in alarm.
// - Searching or registering conditions blink lamp 600 ms on, 600 ms off.
// - Active contexts give on 75, off 75, on 75, off 3 s.
// - During transfer, lamp lights within 1 s after packets exchanged.
// - Each transfer flash lasts about 0.5 s.
// - Voice call connected keeps lamp steadily lit.
// - Data call connected or setting up/tearing down keeps lamp lit.
// - Active-low collision lamp toggles 50 ms high, 50 ms low while active.
// - Active-low speed lamp low whenever 100 Mbit/s selected.
module slpg_top #(
  parameter int unsigned MS_CYCLES = slpg_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Status inputs
  input wire slpg_pkg::slpg_net_t net_in,
  input wire logic collision,
  input wire logic speed_100,
  // Lamp outputs
  output logic net_lamp,
  output logic collision_lamp_n,
  output logic speed_lamp_n
);
  import slpg_pkg::*;

  // Width of the prescaler count
  localparam int unsigned PRE_W = $clog2(MS_CYCLES + 1);

  // Millisecond prescaler state
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic ms_tick;

  // Network lamp pattern state
  slpg_mode_t mode_r, mode_nxt;
  logic [MS_W-1:0] ms_r, ms_nxt;
  logic flash_r, flash_nxt;
  logic pend_r, pend_nxt;
  logic net_lamp_r, net_lamp_nxt;

  // Priority decode of the status inputs
  slpg_mode_t mode_sel;
  logic searching, blocked, call_on;

  // Collision lamp state
  logic [MS_W-1:0] col_ms_r, col_ms_nxt;
  logic col_ph_r, col_ph_nxt;
  logic col_n_r, col_n_nxt;

  // Speed lamp state
  logic spd_n_r, spd_n_nxt;

  // Millisecond tick from a free-running prescaler
  // Never restarted, so the first ms of a phase may be short
  assign ms_tick = (pre_r == PRE_W'(MS_CYCLES - 1));
  always_comb begin
    pre_nxt = ms_tick ? '0 : pre_r + PRE_W'(1);
  end

  // Prescaler register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // Mode selection by priority
  always_comb begin
    blocked = net_in.carrier_off | net_in.sleep | net_in.alarm;
    searching = net_in.sim_absent | net_in.pin_missing | net_in.net_search |
                net_in.user_auth | net_in.net_login;
    // Data call setup and teardown count as a call
    call_on = net_in.voice_connected | net_in.data_connected | net_in.data_setup;
    // Blocking states win over any call or transfer
    if (blocked) begin
      mode_sel = SLPG_OFF;
    end else if (call_on) begin
      mode_sel = SLPG_STEADY;
    end else if (net_in.xfer_active) begin
      mode_sel = SLPG_XFER;
    end else if (net_in.ctx_active) begin
      mode_sel = SLPG_DPULSE;
    end else if (searching) begin
      mode_sel = SLPG_SLOW;
    end else begin
      mode_sel = SLPG_OFF;
    end
  end

  // Pattern timers and network lamp
  // Slow blink: 1200 ms period, lit in its first half
  // Double pulse: two short pulses, then a long dark gap
  // Transfer: one flash per packet seen while no flash runs
  // The lamp is registered from mode_r, two cycles behind the decode
  always_comb begin
    mode_nxt = mode_sel;
    ms_nxt = ms_r;
    flash_nxt = flash_r;
    pend_nxt = pend_r;
    net_lamp_nxt = 1'b0;
    // Every mode change restarts its pattern from the top
    if (mode_sel != mode_r) begin
      ms_nxt = '0;
      flash_nxt = 1'b0;
      pend_nxt = 1'b0;
    end else if (ms_tick) begin
      ms_nxt = ms_r + MS_W'(1);
    end
    unique case (mode_r)
      SLPG_OFF: begin
        net_lamp_nxt = 1'b0;
      end
      SLPG_SLOW: begin
        if (ms_tick && ms_r == MS_W'(2 * SLOW_BLINK_MS - 1)) begin
          ms_nxt = '0;
        end
        net_lamp_nxt = (ms_r < MS_W'(SLOW_BLINK_MS));
      end
      SLPG_DPULSE: begin
        if (ms_tick && ms_r == MS_W'(DP_END_MS - 1)) begin
          ms_nxt = '0;
        end
        net_lamp_nxt = (ms_r < MS_W'(DP_OFF1_MS)) ||
                       (ms_r >= MS_W'(DP_ON2_MS) && ms_r < MS_W'(DP_OFF2_MS));
      end
      SLPG_XFER: begin
        // Packets seen during a flash are not queued
        if (net_in.pkt_exchanged && !flash_r && !pend_r) begin
          pend_nxt = 1'b1;
        end
        // Light as soon as a packet is seen, well within the limit
        if (pend_r) begin
          pend_nxt = 1'b0;
          flash_nxt = 1'b1;
          ms_nxt = '0;
        end else if (flash_r && ms_tick && ms_r == MS_W'(XFER_FLASH_MS - 1)) begin
          flash_nxt = 1'b0;
        end
        net_lamp_nxt = flash_r;
      end
      SLPG_STEADY: begin
        // Lit for as long as the call lasts
        net_lamp_nxt = 1'b1;
      end
      default: begin
        // Unused mode codes keep the lamp dark
        net_lamp_nxt = 1'b0;
      end
    endcase
  end

  // Pattern registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= SLPG_OFF;
      ms_r <= '0;
      flash_r <= 1'b0;
      pend_r <= 1'b0;
      net_lamp_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ms_r <= ms_nxt;
      flash_r <= flash_nxt;
      pend_r <= pend_nxt;
      net_lamp_r <= net_lamp_nxt;
    end
  end

  // Collision and speed lamps
  always_comb begin
    col_ms_nxt = col_ms_r;
    col_ph_nxt = col_ph_r;
    // Counter and phase held at zero while no collision
    if (!collision) begin
      col_ms_nxt = '0;
      col_ph_nxt = 1'b0;
    end else if (ms_tick) begin
      if (col_ms_r == MS_W'(COL_PHASE_MS - 1)) begin
        col_ms_nxt = '0;
        col_ph_nxt = ~col_ph_r;
      end else begin
        col_ms_nxt = col_ms_r + MS_W'(1);
      end
    end
    // First phase of a collision is lit
    col_n_nxt = collision ? col_ph_r : 1'b1;
  end

  // Collision registers; idle is dark at phase zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      col_ms_r <= '0;
      col_ph_r <= 1'b0;
      col_n_r <= 1'b1;
    end else begin
      col_ms_r <= col_ms_nxt;
      col_ph_r <= col_ph_nxt;
      col_n_r <= col_n_nxt;
    end
  end

  // Speed lamp, lit low at 100 Mbit/s
  always_comb begin
    spd_n_nxt = ~speed_100;
  end

  // Speed register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      spd_n_r <= 1'b1;
    end else begin
      spd_n_r <= spd_n_nxt;
    end
  end

  // Registered lamp outputs
  assign net_lamp = net_lamp_r;
  assign collision_lamp_n = col_n_r;
  assign speed_lamp_n = spd_n_r;
endmodule

// *** verification/slpg_checker.sv ***
`timescale 1ns/10ps
module slpg_checker import slpg_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire slpg_net_t net_in,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic net_lamp,
  input wire logic collision_lamp_n,
  input wire logic speed_lamp_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Blocked, call, transfer-only and search-only groups
  wire logic blk = |net_in[13:11], call = |net_in[2:0];
  wire logic xon = net_in[4] & !call & !blk, so = |net_in[10:6] & !(|net_in[5:4]) & !call & !blk;
  sequence pkt_idle; xon [*3] ##0 net_in[3] & !net_lamp; endsequence
  sequence slow_edge; so [*4] ##0 $changed(net_lamp) ##1 so [*8]; endsequence
  spd_map_a:
    assert property ($past(reset_n) |-> speed_lamp_n == !$past(speed_100)) else $error("spd");
  col_idle_a:
    assert property (!collision [*2] |-> collision_lamp_n) else $error("col idle");
  col_cause_a:
    assert property (!collision_lamp_n |-> $past(collision)) else $error("col lit");
  net_block_a:
    assert property (blk [*3] |=> !net_lamp) else $error("blocked lit");
  net_call_a:
    assert property ((call & !blk) [*3] |=> net_lamp) else $error("call dark");
  flash_on_a:
    assert property (pkt_idle |-> ##[1:8] net_lamp) else $error("no flash");
  net_idle_a:
    assert property ((net_in == 14'h0000) [*3] |=> !net_lamp) else $error("idle lit");
  slow_hold_a:
    assert property (slow_edge |-> net_lamp == $past(net_lamp, 8)) else $error("blink");
endmodule
bind slpg_top slpg_checker chk (.*);

// *** verification/slpg_led_model.sv ***
`timescale 1ns/10ps
// Board LEDs, lit at their active level
module slpg_led_model (
  input wire logic net_lamp,
  input wire logic collision_lamp_n,
  input wire logic speed_lamp_n,
  output logic [2:0] lit
);
  assign lit = {net_lamp, !collision_lamp_n, !speed_lamp_n};
endmodule

// *** verification/status_led_pattern_gen_tb.sv ***
`timescale 1ns/10ps
module status_led_pattern_gen_tb;
  import slpg_pkg::*;
  localparam int M = 10;
  logic ref_clk = 1'b0, reset_n = 1'b0, collision = 1'b0, speed_100 = 1'b0;
  slpg_net_t net_in = '0;
  wire logic net_lamp, collision_lamp_n, speed_lamp_n;
  wire logic [2:0] lit;
  int n_mismatch = 0, cmp_count = 0, lo, hi;
  slpg_top #(.MS_CYCLES(M)) uut (.*);
  slpg_led_model leds (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    n_mismatch += (seen !== exp);
    if (seen !== exp) $display("[ERR] %0t seen %0d want %0d", $time, seen, exp);
  endtask
  // Cycles until lamp s reads v; a hang ends the run
  task automatic wt(input int s, input logic v, output int n);
    for (n = 0; lit[s] !== v && n <= 40000; n++) @(negedge ref_clk);
    n_mismatch += (n > 40000);
    if (n > 40000) $display("[ERR] %0t lamp %0d stuck", $time, s);
    if (n > 40000) stop_test();
  endtask
  // Next dark and lit phase of lamp s, in ms rounded up
  task automatic meas(input int s);
    wt(s, 1'b0, lo);
    wt(s, 1'b1, lo);
    wt(s, 1'b0, hi);
    lo = (lo + M - 1) / M;
    hi = (hi + M - 1) / M;
  endtask
  task automatic t_blink();
    net_in.net_search = 1'b1;
    repeat (2) meas(2);
    check(lo, 600);
    check(hi, 600);
    net_in.ctx_active = 1'b1;
    repeat (2) meas(2);
    check(lo, 75);
    meas(2);
    check(lo, 3000);
    check(hi, 75);
    $display("blink done");
  endtask
  task automatic t_xfer();
    net_in.xfer_active = 1'b1;
    repeat (4) @(negedge ref_clk);
    net_in.pkt_exchanged = 1'b1;
    @(negedge ref_clk);
    net_in.pkt_exchanged = 1'b0;
    meas(2);
    check(lo <= XFER_WAIT_MS, 1);
    check(hi, 500);
    $display("xfer done");
  endtask
  task automatic t_col();
    collision = 1'b1;
    speed_100 = 1'b1;
    repeat (2) meas(1);
    check(lo, 50);
    check(hi, 50);
    collision = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(lit[1:0], 2'h1);
    speed_100 = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(lit[0], 1'b0);
    $display("col done");
  endtask
  // Calls override lower modes, blocking overrides calls
  task automatic t_call();
    for (int b = 0; b < 6; b++) begin
      if (b < 3) net_in[2:0] = 3'h1 << b;
      else net_in[b + 8] = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(lit[2], b < 3);
    end
    net_in = '0;
    repeat (4) @(negedge ref_clk);
    check(lit[2], 0);
    $display("call done");
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    t_col();
    t_blink();
    t_xfer();
    t_call();
    stop_test();
  end
endmodule
